// >>> hw/trap_pkg.sv
// Constants and types shared by the trap redirection block
package trap_pkg;
    // ****************************************************************
    // Widths and register map
    // ****************************************************************
    localparam int XLEN = 32;
    localparam logic [11:0] ADDR_VEC = 12'h000;
    localparam logic [11:0] ADDR_EDELEG = 12'h004;
    localparam logic [11:0] ADDR_IDELEG = 12'h008;
    localparam logic [11:0] ADDR_SCAUSE = 12'h00c;
    localparam logic [11:0] ADDR_SEPC = 12'h010;
    localparam logic [11:0] ADDR_STVAL = 12'h014;
    localparam logic [11:0] ADDR_MCAUSE = 12'h018;
    localparam logic [11:0] ADDR_MEPC = 12'h01c;
    localparam logic [11:0] ADDR_MTVAL = 12'h020;
    localparam logic [11:0] ADDR_STATUS = 12'h024;
    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int MODE_W = 2;
    localparam int CAUSE_W = 5;
    localparam int INT_FLAG_BIT = XLEN - 1;
    localparam int ECALL_U_BIT = 8;
    localparam int ECALL_M_BIT = 11;
    localparam int SUPER_TIMER_INT_BIT = 5;
    localparam logic [XLEN-1:0] MACHINE_INT_MASK = 32'h0000_0888;
    localparam logic [XLEN-1:0] EDELEG_IMPL = 32'h0000_b3ff;
    localparam logic [XLEN-1:0] IDELEG_IMPL = 32'h0000_0222;
    localparam logic [XLEN-1:0] IDELEG_FIXED_ONE = 32'h0000_0000;
    localparam logic [XLEN-1:0] VEC_RESET = 32'h0000_0000;
    localparam logic [1:0] VEC_ALIGN_VECTORED = 2'h0;
    // Status word bit positions
    localparam int ST_SUP_EN = 1;
    localparam int ST_SUP_PREV_EN = 5;
    localparam int ST_SUP_PREV_PRIV = 8;
    localparam int ST_MIE = 3;
    localparam int ST_MACH_PREV_EN = 7;
    localparam int ST_MACH_PREV_PRIV = 11;
    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        PRIV_USER = 2'h0,
        PRIV_SUPER = 2'h1,
        PRIV_MACHINE = 2'h3
    } priv_type;
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_VECTORED = 2'h1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// >>> hw/trap_csr_if.sv
// Register write port and read data carried between the bus slave and the trap state
`timescale 1ns/10ps
interface trap_csr_if;
    import trap_pkg::*;
    logic we;
    logic [11:0] addr;
    logic [XLEN-1:0] wdata;
    logic [XLEN-1:0] rdata;
    modport bus (output we, output addr, output wdata, input rdata);
    modport regs (input we, input addr, input wdata, output rdata);
endinterface

// >>> hw/axil_slave.sv
// AXI4-Lite slave that turns bus accesses into register strobes
`timescale 1ns/10ps
module axil_slave
    import trap_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    trap_csr_if.bus csr
);
    logic aw_reg;
    logic w_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;

    // ****************************************************************
    // Write channels, either order
    // ****************************************************************
    assign awready = !aw_reg && !bvalid;
    assign wready = !w_reg && !bvalid;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            bvalid <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_reg <= 1'b1;
                wdata_reg <= wdata;
            end
            if (aw_reg && w_reg) begin
                aw_reg <= 1'b0;
                w_reg <= 1'b0;
                bvalid <= 1'b1;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    // Partial strobes are taken as full words; registers are word fields
    assign bresp = AXI_OKAY;
    assign csr.we = aw_reg && w_reg;
    assign csr.addr = {awaddr_reg[11:2], 2'h0};
    assign csr.wdata = wdata_reg;

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign arready = !rvalid;
    assign rresp = AXI_OKAY;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= csr.rdata;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// >>> hw/trap_vector_and_delegation.sv
// Trap target address and supervisor delegation unit
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - Trap vector register always present, legal-value masked
// - Vector base always four byte aligned
// - Mode 0 direct, 1 vectored, others reserved
// - Direct mode: every machine trap to base
// - Vectored: interrupts to base plus four cause
// - Interrupt cause 0 goes to base
// - Vectored mode may demand stricter base alignment
// - Undelegated traps all go to machine
// - Delegation registers exist only with supervisor
// - Delegated trap from S or U to supervisor
// - Delegated trap writes supervisor cause, pc, state
// - Delegated trap leaves machine trap state alone
// - Unsupported delegation bits read back zero
// - No exception or machine interrupt bit fixed one
// - Traps in machine mode stay in machine
// - Delegated trap in supervisor stays supervisor
// - Delegated interrupts masked in machine mode
// - Exception delegation indexed by exception code
// - Interrupt delegation matches pending layout
// - Exception delegation bit 11 reads zero
// - Interrupt to machine only when undelegated
module trap_vector_and_delegation
    import trap_pkg::*;
#(
    parameter bit HAS_SUPER = 1'b1,
    parameter bit VEC_WRITABLE = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trap_valid,
    input wire logic trap_is_int,
    input wire logic [CAUSE_W-1:0] trap_cause,
    input wire logic [XLEN-1:0] trap_pc,
    input wire logic [XLEN-1:0] trap_value,
    input wire logic [1:0] cur_priv,
    input wire logic [XLEN-1:0] int_pending,
    output logic [XLEN-1:0] int_delegated_mask,
    output logic target_valid,
    output logic [XLEN-1:0] target_pc,
    output logic [1:0] target_priv
);
    trap_csr_if csr ();
    logic [XLEN-1:0] vec_reg;
    logic [XLEN-1:0] edeleg_reg;
    logic [XLEN-1:0] ideleg_reg;
    logic [XLEN-1:0] scause_reg;
    logic [XLEN-1:0] sepc_reg;
    logic [XLEN-1:0] stval_reg;
    logic [XLEN-1:0] mcause_reg;
    logic [XLEN-1:0] mepc_reg;
    logic [XLEN-1:0] mtval_reg;
    logic super_int_enable;
    logic super_prev_int_enable;
    logic super_prev_privilege;
    logic machine_int_enable;
    logic machine_prev_int_enable;
    logic [1:0] machine_prev_privilege;
    logic [XLEN-1:0] status_word;
    logic deleg_bit;
    logic to_super;
    logic [XLEN-1:0] base;
    logic [XLEN-1:0] cause_word;
    logic [XLEN-1:0] target_next;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Trims a written vector word to a legal value
    function automatic logic [XLEN-1:0] legal_vec(input logic [XLEN-1:0] v,
                                                  input logic [XLEN-1:0] old);
        logic [XLEN-1:0] r;
        r = v;
        if (v[MODE_W-1:0] > MODE_VECTORED) begin
            r[MODE_W-1:0] = old[MODE_W-1:0];
        end
        return r;
    endfunction

    function automatic logic [XLEN-1:0] vec_base(input logic [XLEN-1:0] v);
        logic [XLEN-1:0] b;
        b = {v[XLEN-1:MODE_W], {MODE_W{1'b0}}};
        if (v[MODE_W-1:0] == MODE_VECTORED) begin
            b[MODE_W+1:MODE_W] = b[MODE_W+1:MODE_W]
                & ~VEC_ALIGN_VECTORED;
        end
        return b;
    endfunction

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    axil_slave bus_u (
        .clk(clk),
        .resetn(resetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .csr(csr.bus)
    );

    // ****************************************************************
    // Trap routing
    // ****************************************************************
    assign deleg_bit = trap_is_int ? ideleg_reg[trap_cause]
                                   : edeleg_reg[trap_cause];
    // Never downward from machine; horizontal in supervisor is fine
    assign to_super = HAS_SUPER && deleg_bit
                      && (cur_priv != PRIV_MACHINE);
    assign int_delegated_mask = ideleg_reg;
    assign base = vec_base(vec_reg);
    assign cause_word = {trap_is_int, {(XLEN-CAUSE_W-1){1'b0}}, trap_cause};

    always_comb begin
        target_next = base;
        if (!to_super && trap_is_int
            && vec_reg[MODE_W-1:0] == MODE_VECTORED) begin
            target_next = base
                + {{(XLEN-CAUSE_W-2){1'b0}}, trap_cause, 2'h0};
        end
    end

    // Supervisor vector not modelled; pc stays the machine base, target_priv tells the pipeline the mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            target_valid <= 1'b0;
            target_pc <= 32'h0000_0000;
            target_priv <= PRIV_MACHINE;
        end else begin
            target_valid <= trap_valid;
            if (trap_valid) begin
                target_pc <= target_next;
                target_priv <= to_super ? PRIV_SUPER : PRIV_MACHINE;
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vec_reg <= VEC_RESET;
            edeleg_reg <= 32'h0000_0000;
            ideleg_reg <= IDELEG_FIXED_ONE;
        end else if (csr.we) begin
            if (csr.addr == ADDR_VEC) begin
                if (VEC_WRITABLE) begin
                    vec_reg <= legal_vec(csr.wdata, vec_reg);
                end
            end else if (csr.addr == ADDR_EDELEG) begin
                // Bit 11 is never implemented, machine calls stay put
                edeleg_reg <= HAS_SUPER ? (csr.wdata & EDELEG_IMPL)
                    : 32'h0;
            end else if (csr.addr == ADDR_IDELEG) begin
                ideleg_reg <= HAS_SUPER
                    ? ((csr.wdata & IDELEG_IMPL & ~MACHINE_INT_MASK)
                    | IDELEG_FIXED_ONE) : 32'h0;
            end
        end
    end

    // ****************************************************************
    // Trap state
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scause_reg <= 32'h0000_0000;
            sepc_reg <= 32'h0000_0000;
            stval_reg <= 32'h0000_0000;
            super_int_enable <= 1'b0;
            super_prev_int_enable <= 1'b0;
            super_prev_privilege <= 1'b0;
        end else if (trap_valid && to_super) begin
            scause_reg <= cause_word;
            sepc_reg <= trap_pc;
            stval_reg <= trap_value;
            super_prev_privilege <= (cur_priv == PRIV_SUPER);
            super_prev_int_enable <= super_int_enable;
            super_int_enable <= 1'b0;
        end else if (csr.we && !trap_valid) begin
            if (csr.addr == ADDR_SCAUSE) begin
                scause_reg <= csr.wdata;
            end else if (csr.addr == ADDR_SEPC) begin
                sepc_reg <= csr.wdata;
            end else if (csr.addr == ADDR_STVAL) begin
                stval_reg <= csr.wdata;
            end else if (csr.addr == ADDR_STATUS) begin
                super_int_enable <= csr.wdata[ST_SUP_EN];
                super_prev_int_enable <= csr.wdata[ST_SUP_PREV_EN];
                super_prev_privilege <= csr.wdata[ST_SUP_PREV_PRIV];
            end
        end
    end

    // Machine state moves only on machine traps and bus writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mcause_reg <= 32'h0000_0000;
            mepc_reg <= 32'h0000_0000;
            mtval_reg <= 32'h0000_0000;
            machine_int_enable <= 1'b0;
            machine_prev_int_enable <= 1'b0;
            machine_prev_privilege <= PRIV_MACHINE;
        end else if (trap_valid && !to_super) begin
            mcause_reg <= cause_word;
            mepc_reg <= trap_pc;
            mtval_reg <= trap_value;
            machine_prev_privilege <= cur_priv;
            machine_prev_int_enable <= machine_int_enable;
            machine_int_enable <= 1'b0;
        end else if (csr.we && !trap_valid) begin
            if (csr.addr == ADDR_MCAUSE) begin
                mcause_reg <= csr.wdata;
            end else if (csr.addr == ADDR_MEPC) begin
                mepc_reg <= csr.wdata;
            end else if (csr.addr == ADDR_MTVAL) begin
                mtval_reg <= csr.wdata;
            end else if (csr.addr == ADDR_STATUS) begin
                machine_int_enable <= csr.wdata[ST_MIE];
                machine_prev_int_enable <= csr.wdata[ST_MACH_PREV_EN];
                machine_prev_privilege
                    <= csr.wdata[ST_MACH_PREV_PRIV+1:ST_MACH_PREV_PRIV];
            end
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_SUP_EN] = super_int_enable;
        status_word[ST_SUP_PREV_EN] = super_prev_int_enable;
        status_word[ST_SUP_PREV_PRIV] = super_prev_privilege;
        status_word[ST_MIE] = machine_int_enable;
        status_word[ST_MACH_PREV_EN] = machine_prev_int_enable;
        status_word[ST_MACH_PREV_PRIV+1:ST_MACH_PREV_PRIV]
            = machine_prev_privilege;
    end

    always_comb begin
        if (s_axi_araddr == ADDR_VEC) begin
            csr.rdata = vec_reg;
        end else if (s_axi_araddr == ADDR_EDELEG) begin
            csr.rdata = edeleg_reg;
        end else if (s_axi_araddr == ADDR_IDELEG) begin
            csr.rdata = ideleg_reg;
        end else if (s_axi_araddr == ADDR_SCAUSE) begin
            csr.rdata = scause_reg;
        end else if (s_axi_araddr == ADDR_SEPC) begin
            csr.rdata = sepc_reg;
        end else if (s_axi_araddr == ADDR_STVAL) begin
            csr.rdata = stval_reg;
        end else if (s_axi_araddr == ADDR_MCAUSE) begin
            csr.rdata = mcause_reg;
        end else if (s_axi_araddr == ADDR_MEPC) begin
            csr.rdata = mepc_reg;
        end else if (s_axi_araddr == ADDR_MTVAL) begin
            csr.rdata = mtval_reg;
        end else if (s_axi_araddr == ADDR_STATUS) begin
            csr.rdata = status_word;
        end else begin
            csr.rdata = 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    mach_stays_m_a: assert property (
        trap_valid && cur_priv == PRIV_MACHINE
        |=> target_priv == PRIV_MACHINE) else $error("machine trap left M");
    direct_base_a: assert property (
        trap_valid && !to_super && vec_reg[MODE_W-1:0] == MODE_DIRECT
        |=> target_pc == $past(base)) else $error("direct target wrong");
    vec_int_a: assert property (
        trap_valid && !to_super && trap_is_int
        && vec_reg[MODE_W-1:0] == MODE_VECTORED
        |=> target_pc == $past(base) + 4 * $past(trap_cause))
        else $error("vectored target wrong");
    vec_exc_a: assert property (
        trap_valid && !to_super && !trap_is_int
        |=> target_pc == $past(base)) else $error("exception target");
    base_align_a: assert property (
        target_pc[MODE_W-1:0] == {MODE_W{1'b0}})
        else $error("target misaligned");
    mode_legal_a: assert property (
        vec_reg[MODE_W-1:0] <= MODE_VECTORED)
        else $error("reserved mode held");
    deleg_route_a: assert property (
        trap_valid && deleg_bit && cur_priv != PRIV_MACHINE
        |=> target_priv == PRIV_SUPER) else $error("delegated trap not in S");
    sup_update_a: assert property (
        trap_valid && to_super
        |=> sepc_reg == $past(trap_pc) && !super_int_enable
        && super_prev_int_enable == $past(super_int_enable))
        else $error("supervisor state not saved");
    sup_cause_a: assert property (
        trap_valid && to_super
        |=> scause_reg == $past(cause_word) && stval_reg == $past(trap_value))
        else $error("supervisor cause not saved");
    mach_keep_a: assert property (
        trap_valid && to_super
        |=> $stable(mepc_reg) && $stable(mcause_reg) && $stable(mtval_reg)
        && $stable(machine_prev_privilege)
        && $stable(machine_prev_int_enable))
        else $error("machine state changed");
    mach_save_a: assert property (
        trap_valid && !to_super
        |=> mepc_reg == $past(trap_pc) && mcause_reg == $past(cause_word))
        else $error("machine state not saved");
    bit11_zero_a: assert property (
        !edeleg_reg[ECALL_M_BIT] && (ideleg_reg & MACHINE_INT_MASK) == '0)
        else $error("forbidden delegation bit");

    deleg_cov: cover property (trap_valid && to_super);
    vec_cov: cover property (trap_valid && trap_is_int
        && vec_reg[1:0] == MODE_VECTORED && !to_super);
    horiz_cov: cover property (trap_valid && to_super
        && cur_priv == PRIV_SUPER);
endmodule

// >>> sim/trap_pipe_model.sv
// Pipeline stand-in that raises at most one trap per request from the bench
`timescale 1ns/10ps
module trap_pipe_model
    import trap_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic g_int,
    input wire logic [CAUSE_W-1:0] g_cause,
    input wire logic [1:0] g_priv,
    input wire logic [XLEN-1:0] g_pc,
    input wire logic [XLEN-1:0] deleg_mask,
    output logic trap_valid,
    output logic trap_is_int,
    output logic [CAUSE_W-1:0] trap_cause,
    output logic [XLEN-1:0] trap_pc,
    output logic [XLEN-1:0] trap_value,
    output logic [1:0] cur_priv
);
    // Idle pc and value fields flip every cycle so stale values never match
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trap_valid <= 1'b0;
            trap_is_int <= 1'b0;
            trap_cause <= '0;
            trap_pc <= '0;
            trap_value <= '0;
            cur_priv <= PRIV_MACHINE;
        end else if (go) begin
            // Delegated interrupt never taken while in machine mode
            trap_valid <= !(g_int && g_priv == PRIV_MACHINE
                && deleg_mask[g_cause]);
            trap_is_int <= g_int;
            trap_cause <= g_cause;
            trap_pc <= g_pc;
            trap_value <= ~g_pc;
            cur_priv <= g_priv;
        end else begin
            trap_valid <= 1'b0;
            trap_pc <= ~trap_pc;
            trap_value <= ~trap_value;
        end
    end
endmodule

// >>> sim/tb_trap_vector_and_delegation.sv
// Self-checking bench for the trap redirection block
`timescale 1ns/10ps
module tb_trap_vector_and_delegation;
    import trap_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, target_priv, cur_priv;
    logic go = 0, g_int = 0;
    logic [CAUSE_W-1:0] g_cause = '0, trap_cause;
    logic [1:0] g_priv = 2'h3;
    logic [XLEN-1:0] g_pc = '0, trap_pc, trap_value, dmask, target_pc;
    logic trap_valid, trap_is_int, target_valid;
    int n_fail = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    trap_pipe_model pipe (.clk(clk), .resetn(resetn), .go(go),
        .g_int(g_int), .g_cause(g_cause), .g_priv(g_priv), .g_pc(g_pc),
        .deleg_mask(dmask), .trap_valid(trap_valid),
        .trap_is_int(trap_is_int), .trap_cause(trap_cause),
        .trap_pc(trap_pc), .trap_value(trap_value), .cur_priv(cur_priv));
    trap_vector_and_delegation uut (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .trap_valid(trap_valid),
        .trap_is_int(trap_is_int), .trap_cause(trap_cause),
        .trap_pc(trap_pc), .trap_value(trap_value), .cur_priv(cur_priv),
        .int_pending(32'h0000_0000), .int_delegated_mask(dmask),
        .target_valid(target_valid), .target_pc(target_pc),
        .target_priv(target_priv));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        n_fail++;
        $display("MISMATCH %0t %s timed out", $time, what);
        report_and_stop();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) hang("write");
        chk(32'(bresp), 32'(AXI_OKAY), "write response");
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) hang("read");
        chk(rdata, exp, "read data");
        chk(32'(rresp), 32'(AXI_OKAY), "read response");
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] pcv(input logic [4:0] c);
        return {27'h000_0800, c};
    endfunction
    // Pc is only judged for machine targets; supervisor vector lies outside
    task automatic trap(input logic i, input logic [4:0] c,
        input logic [1:0] p, input logic [1:0] ep, input logic [31:0] epc);
        int n;
        @(posedge clk);
        go <= 1'b1;
        g_int <= i;
        g_cause <= c;
        g_priv <= p;
        g_pc <= pcv(c);
        @(posedge clk);
        go <= 1'b0;
        for (n = 0; n < 10 && !target_valid; n++) @(posedge clk);
        if (n == 10) hang("trap");
        chk(32'(target_priv), 32'(ep), "target privilege");
        if (ep == PRIV_MACHINE) chk(target_pc, epc, "target pc");
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        rd(ADDR_VEC, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_1800);
        wr(ADDR_EDELEG, 32'hffff_ffff);
        rd(ADDR_EDELEG, 32'h0000_b3ff);
        wr(ADDR_IDELEG, 32'hffff_ffff);
        rd(ADDR_IDELEG, 32'h0000_0222);
        chk(dmask, 32'h0000_0222, "delegated mask");
        rd(12'h100, 32'h0000_0000);
        wr(ADDR_VEC, 32'h0000_0401);
        rd(ADDR_VEC, 32'h0000_0401);
        // Reserved mode write keeps the old mode, base still aligned
        wr(ADDR_VEC, 32'h0000_0803);
        rd(ADDR_VEC, 32'h0000_0801);
    endtask
    task automatic t_vectors();
        wr(ADDR_EDELEG, 32'h0000_0000);
        wr(ADDR_IDELEG, 32'h0000_0000);
        wr(ADDR_VEC, 32'h0000_0400);
        trap(1, 5'd7, 2'h3, 2'h3, 32'h0000_0400);
        trap(0, 5'd2, 2'h0, 2'h3, 32'h0000_0400);
        wr(ADDR_VEC, 32'h0000_0401);
        trap(1, 5'd7, 2'h3, 2'h3, 32'h0000_041c);
        trap(1, 5'd0, 2'h1, 2'h3, 32'h0000_0400);
        trap(0, 5'd2, 2'h3, 2'h3, 32'h0000_0400);
        trap(1, 5'd5, 2'h0, 2'h3, 32'h0000_0414);
    endtask
    task automatic t_delegation();
        wr(ADDR_EDELEG, 32'h0000_0104);
        wr(ADDR_IDELEG, 32'h0000_0020);
        trap(0, 5'd3, 2'h0, 2'h3, 32'h0000_0400);
        rd(ADDR_MCAUSE, 32'h0000_0003);
        rd(ADDR_MEPC, pcv(5'd3));
        trap(0, 5'd8, 2'h3, 2'h3, 32'h0000_0400);
        wr(ADDR_STATUS, 32'h0000_1802);
        trap(0, 5'd2, 2'h1, 2'h1, 32'h0);
        rd(ADDR_SCAUSE, 32'h0000_0002);
        rd(ADDR_SEPC, pcv(5'd2));
        rd(ADDR_STVAL, ~pcv(5'd2));
        rd(ADDR_STATUS, 32'h0000_1920);
        rd(ADDR_MCAUSE, 32'h0000_0008);
        rd(ADDR_MEPC, pcv(5'd8));
        rd(ADDR_MTVAL, ~pcv(5'd8));
        trap(0, 5'd8, 2'h0, 2'h1, 32'h0);
        trap(1, 5'd5, 2'h0, 2'h1, 32'h0);
        rd(ADDR_SCAUSE, 32'h8000_0005);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_vectors();
        t_delegation();
        report_and_stop();
    end
endmodule
